/* include/tmcs_pkg.sv */
// package: register map, field layout, prescaler taps, clock-edge and mode codes of the timer config
package tmcs_pkg;
	localparam int NCH   = 5;                 // channels 0..4
	localparam int DIV_W = 10;                // prescaler counter, up to /1024
	localparam int NDIV  = 6;                 // taps /1 /4 /16 /64 /256 /1024

	// prescaler tap indices
	localparam int DIV1    = 0;
	localparam int DIV4    = 1;
	localparam int DIV16   = 2;
	localparam int DIV64   = 3;
	localparam int DIV256  = 4;
	localparam int DIV1024 = 5;

	// register map: control at 2*ch, mode at 2*ch+1, sync register last
	localparam logic [3:0] ADDR_SYNC = 4'hA;

	// control register fields
	localparam int CS_LSB   = 0;              // clock select, 3 bits
	localparam int EDGE_LSB = 3;              // clock edge, 2 bits
	localparam int CLR_TOP  = 7;              // top counter-clear bit
	// mode register fields
	localparam int BUF_B    = 5;              // register D buffers register B
	localparam int BUF_A    = 4;              // register C buffers register A
	localparam int MODE_LSB = 0;              // operating mode, 4 bits

	// reset values and write masks
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam logic [7:0] MODE_RST    = 8'hC0;
	localparam logic [7:0] MODE_RSV    = 8'hC0; // reserved bits read as one
	localparam logic [4:0] SYNC_RST    = 5'h00;
	localparam logic [7:0] CTRL_WM     = 8'hFF;
	localparam logic [7:0] CTRL_WM_NAR = 8'h7F; // channels 1 and 2
	localparam logic [7:0] MODE_WM     = 8'h3F;
	localparam logic [7:0] MODE_WM_NAR = 8'h0F; // channels 1 and 2

	// clock-edge codes (1x counts both edges)
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	// operating mode codes
	localparam logic [3:0] MD_NORMAL = 4'h0;
	localparam logic [3:0] MD_PWM1   = 4'h2;
	localparam logic [3:0] MD_PWM2   = 4'h3;
	localparam logic [1:0] MD_PHASE  = 2'h1;  // upper two bits of phase modes
	localparam logic [3:0] MD_RSPWM  = 4'h8;
	localparam logic [3:0] MD_CPWM1  = 4'hD;
	localparam logic [3:0] MD_CPWM2  = 4'hE;
	localparam logic [3:0] MD_CPWM3  = 4'hF;
endpackage : tmcs_pkg

/* include/tmcs_tick_if.sv */
// interface: prescaler taps and external pin edges toward the channel logic
`timescale 1ns/1ps
`default_nettype none
interface tmcs_tick_if;
	logic [tmcs_pkg::NDIV-1:0] pre_rise;  // rising edge of each divided clock
	logic [tmcs_pkg::NDIV-1:0] pre_fall;  // falling edge of each divided clock
	logic [3:0]                pin_rise;  // pins a..d, one-cycle pulses
	logic [3:0]                pin_fall;
	modport pre_src (output pre_rise, output pre_fall);
	modport pin_src (output pin_rise, output pin_fall);
	modport sink    (input pre_rise, input pre_fall, input pin_rise,
		input pin_fall);
endinterface : tmcs_tick_if
`default_nettype wire

/* hdl/tmcs_prescaler.sv */
// module: free-running prescaler giving edge pulses of the divided clocks
`timescale 1ns/1ps
`default_nettype none
module tmcs_prescaler (
	input  wire logic    sys_clk_i,
	input  wire logic    nrst_i,
	input  wire logic    ce_i,
	tmcs_tick_if.pre_src tick
);
	typedef struct packed {
		logic [tmcs_pkg::DIV_W-1:0] cnt;
		logic [tmcs_pkg::NDIV-1:0]  rise;
		logic [tmcs_pkg::NDIV-1:0]  fall;
	} tmcs_pre_s;

	tmcs_pre_s r_reg;
	tmcs_pre_s r_next;

	// low bits that make up one period of tap k (divide by 4**k)
	function automatic logic [tmcs_pkg::DIV_W-1:0] tap_mask(input int k);
		return tmcs_pkg::DIV_W'((1 << (2 * k)) - 1);
	endfunction : tap_mask

	// point half way through the period; tap 0 has no half, so it aliases rise
	function automatic logic [tmcs_pkg::DIV_W-1:0] tap_half(input int k);
		return (k == 0) ? '0 : tmcs_pkg::DIV_W'((1 << (2 * k - 1)) - 1);
	endfunction : tap_half

	////////////////////////////////////////////////////////////////////////
	// one counter serves every tap, so all divided clocks stay in phase
	always_comb begin
		r_next = r_reg;
		if (ce_i) begin
			r_next.cnt = r_reg.cnt + 1'b1;
			for (int k = 0; k < tmcs_pkg::NDIV; k++) begin
				r_next.rise[k] = (r_reg.cnt & tap_mask(k)) == tap_mask(k);
				r_next.fall[k] = (r_reg.cnt & tap_mask(k)) == tap_half(k);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign tick.pre_rise = r_reg.rise;
	assign tick.pre_fall = r_reg.fall;
endmodule : tmcs_prescaler
`default_nettype wire

/* hdl/tmcs_pin_sync.sv */
// module: synchroniser and edge detector for the four external clock pins
`timescale 1ns/1ps
`default_nettype none
module tmcs_pin_sync (
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	input  wire logic [3:0] pins_i,
	tmcs_tick_if.pin_src    tick
);
	typedef struct packed {
		logic [3:0] s1;    // metastability catcher, read only by s2
		logic [3:0] s2;
		logic [3:0] s3;    // previous level for edge detection
		logic [3:0] rise;
		logic [3:0] fall;
	} tmcs_pin_s;

	tmcs_pin_s r_reg;
	tmcs_pin_s r_next;

	////////////////////////////////////////////////////////////////////////
	// each pin edge yields exactly one pulse; pins faster than half the
	// system clock alias and lose counts
	always_comb begin
		r_next = r_reg;
		if (ce_i) begin
			r_next.s1   = pins_i;
			r_next.s2   = r_reg.s1;
			r_next.s3   = r_reg.s2;
			r_next.rise = r_reg.s2 & ~r_reg.s3;
			r_next.fall = ~r_reg.s2 & r_reg.s3;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign tick.pin_rise = r_reg.rise;
	assign tick.pin_fall = r_reg.fall;

	////////////////////////////////////////////////////////////////////////
	chk_pin_single_pulse: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		ce_i && r_reg.rise[0] |=> !r_reg.rise[0])
		else $error("pin a edge produced more than one count pulse");
endmodule : tmcs_pin_sync
`default_nettype wire

/* hdl/tmcs_timer_cfg.sv */
// module: per-channel clock select, mode registers and sync membership
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - channel 0 counts on clock /1, /4, or external pins a to d.
// - channel 1 counts on /4, /16, /64, /256, pins a and b, or channel 2 wrap.
// - channel 1 ignores its clock select while in phase counting mode.
// - channel 2 counts on /1, /4 or pins a to c; ignored in phase mode.
// - channels 3 and 4 count on /4, /16, /256, /1024 or pins a and b.
// - every channel has its own 8-bit read-write mode register.
// - mode bits 7 and 6 read as one; software writes ones there.
// - mode bit 5 makes register D buffer B and mutes D events.
// - mode bit 4 makes register C buffer A and mutes C events.
// - channels 1 and 2 read mode bits 5 and 4 as zero, unwritable.
// - channels 1 and 2 read control bit 7 as zero, unwritable.
// - a channel joins synchronous operation only when its sync bit is one.
// - mode bits 3 to 0 select the channel operating mode.
// - only the listed mode codes are legal; others are flagged.
// - edge field counts rising, falling (01) or both edges (1x).
module tmcs_timer_cfg (
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       ext_clock_pin_a_i,
	input  wire logic       ext_clock_pin_b_i,
	input  wire logic       ext_clock_pin_c_i,
	input  wire logic       ext_clock_pin_d_i,
	input  wire logic       ch2_overflow_i,
	input  wire logic       ch2_underflow_i,
	input  wire logic [4:0] cmp_c_event_i,
	input  wire logic [4:0] cmp_d_event_i,
	output logic      [4:0] count_tick_o,
	output logic      [4:0] buffer_pair_a_o,
	output logic      [4:0] buffer_pair_b_o,
	output logic      [4:0] c_event_o,
	output logic      [4:0] d_event_o,
	output logic      [4:0] sync_member_o,
	output logic      [4:0] phase_mode_o,
	output logic      [4:0] mode_error_o
);
	typedef struct packed {
		logic [tmcs_pkg::NCH-1:0][7:0] ctrl;
		logic [tmcs_pkg::NCH-1:0][7:0] mode;
		logic [tmcs_pkg::NCH-1:0]      sync;
		logic [7:0]                    rdata;
		logic [tmcs_pkg::NCH-1:0]      tick;
		logic [tmcs_pkg::NCH-1:0]      c_ev;
		logic [tmcs_pkg::NCH-1:0]      d_ev;
	} tmcs_cfg_s;

	tmcs_cfg_s r_reg;
	tmcs_cfg_s r_next;

	tmcs_tick_if tick ();

	////////////////////////////////////////////////////////////////////////
	// shared time bases: prescaler taps and synchronised pin edges
	tmcs_prescaler u_prescaler (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.ce_i      (ce_i),
		.tick      (tick.pre_src)
	);

	tmcs_pin_sync u_pin_sync (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.ce_i      (ce_i),
		.pins_i    ({ext_clock_pin_d_i, ext_clock_pin_c_i,
			ext_clock_pin_b_i, ext_clock_pin_a_i}),
		.tick      (tick.pin_src)
	);

	////////////////////////////////////////////////////////////////////////
	// channels 1 and 2 lack registers C and D and the top clear bit
	function automatic logic narrow_ch(input int ch);
		return (ch == 1) || (ch == 2);
	endfunction : narrow_ch

	// phase counting only takes effect on the narrow channels
	function automatic logic in_phase(input int ch, input logic [3:0] md);
		return narrow_ch(ch) && (md[3:2] == tmcs_pkg::MD_PHASE);
	endfunction : in_phase

	// legal operating modes per channel; anything else raises the error flag
	function automatic logic mode_bad(input int ch, input logic [3:0] md);
		logic ok;
		ok = 1'b0;
		case (md)
			tmcs_pkg::MD_NORMAL,
			tmcs_pkg::MD_PWM1:  ok = 1'b1;
			tmcs_pkg::MD_PWM2:  ok = (ch != 3) && (ch != 4);
			tmcs_pkg::MD_RSPWM,
			tmcs_pkg::MD_CPWM1,
			tmcs_pkg::MD_CPWM2,
			tmcs_pkg::MD_CPWM3: ok = (ch == 3);
			default:            ok = (md[3:2] == tmcs_pkg::MD_PHASE) &&
				narrow_ch(ch);
		endcase
		return !ok;
	endfunction : mode_bad

	// returns {rising, falling} of the source picked by the clock select;
	// codes without a documented source count nothing
	function automatic logic [1:0] src_pick(
		input int                        ch,
		input logic [2:0]                cs,
		input logic [tmcs_pkg::NDIV-1:0] pr,
		input logic [tmcs_pkg::NDIV-1:0] pf,
		input logic [3:0]                er,
		input logic [3:0]                ef,
		input logic                      wrap
	);
		logic [1:0] s;
		s = 2'h0;
		case (ch)
			0: begin
				case (cs)
					3'h0:    s = {pr[tmcs_pkg::DIV1], pf[tmcs_pkg::DIV1]};
					3'h1:    s = {pr[tmcs_pkg::DIV4], pf[tmcs_pkg::DIV4]};
					3'h4, 3'h5, 3'h6,
					3'h7:    s = {er[cs[1:0]], ef[cs[1:0]]};
					default: s = 2'h0;
				endcase
			end
			1: begin
				case (cs)
					3'h1:    s = {pr[tmcs_pkg::DIV4], pf[tmcs_pkg::DIV4]};
					3'h2:    s = {pr[tmcs_pkg::DIV16], pf[tmcs_pkg::DIV16]};
					3'h3:    s = {pr[tmcs_pkg::DIV64], pf[tmcs_pkg::DIV64]};
					3'h4:    s = {er[0], ef[0]};
					3'h5:    s = {er[1], ef[1]};
					3'h6:    s = {pr[tmcs_pkg::DIV256], pf[tmcs_pkg::DIV256]};
					3'h7:    s = {wrap, wrap};  // any edge setting counts once
					default: s = 2'h0;
				endcase
			end
			2: begin
				case (cs)
					3'h0:    s = {pr[tmcs_pkg::DIV1], pf[tmcs_pkg::DIV1]};
					3'h1:    s = {pr[tmcs_pkg::DIV4], pf[tmcs_pkg::DIV4]};
					3'h4, 3'h5,
					3'h6:    s = {er[cs[1:0]], ef[cs[1:0]]};
					default: s = 2'h0;
				endcase
			end
			default: begin
				case (cs)
					3'h1:    s = {pr[tmcs_pkg::DIV4], pf[tmcs_pkg::DIV4]};
					3'h2:    s = {pr[tmcs_pkg::DIV16], pf[tmcs_pkg::DIV16]};
					3'h4:    s = {pr[tmcs_pkg::DIV256], pf[tmcs_pkg::DIV256]};
					3'h5:    s = {pr[tmcs_pkg::DIV1024],
						pf[tmcs_pkg::DIV1024]};
					3'h6:    s = {er[0], ef[0]};
					3'h7:    s = {er[1], ef[1]};
					default: s = 2'h0;
				endcase
			end
		endcase
		return s;
	endfunction : src_pick

	// edge field: 00 rising, 01 falling, 1x both
	function automatic logic edge_sel(input logic [1:0] eg,
		input logic [1:0] s);
		if (eg[1])
			return s[1] | s[0];
		else if (eg == tmcs_pkg::EDGE_FALL)
			return s[0];
		else
			return s[1];
	endfunction : edge_sel

	////////////////////////////////////////////////////////////////////////
	// register file, count ticks and event gating; all state freezes on !ce
	always_comb begin
		logic [2:0] ch;
		logic [1:0] src;
		logic [3:0] md;
		logic [7:0] cr;
		r_next = r_reg;
		ch     = addr_i[3:1];
		src    = 2'h0;
		md     = 4'h0;
		cr     = 8'h00;
		if (ce_i) begin
			// writes; reserved bits are forced so reads show them fixed
			if (wr_i && (addr_i == tmcs_pkg::ADDR_SYNC)) begin
				r_next.sync = wdata_i[tmcs_pkg::NCH-1:0];
			end else if (wr_i && (addr_i < tmcs_pkg::ADDR_SYNC)) begin
				if (addr_i[0]) begin
					r_next.mode[ch] = (wdata_i & (narrow_ch(int'(ch)) ?
						tmcs_pkg::MODE_WM_NAR : tmcs_pkg::MODE_WM)) |
						tmcs_pkg::MODE_RSV;
				end else begin
					r_next.ctrl[ch] = wdata_i & (narrow_ch(int'(ch)) ?
						tmcs_pkg::CTRL_WM_NAR : tmcs_pkg::CTRL_WM);
				end
			end
			// reads answer one cycle later; unmapped addresses read zero
			r_next.rdata = 8'h00;
			if (rd_i && (addr_i == tmcs_pkg::ADDR_SYNC))
				r_next.rdata = {3'h0, r_reg.sync};
			else if (rd_i && (addr_i < tmcs_pkg::ADDR_SYNC))
				r_next.rdata = addr_i[0] ? r_reg.mode[ch] : r_reg.ctrl[ch];
			// per-channel count source and event gating
			for (int k = 0; k < tmcs_pkg::NCH; k++) begin
				cr  = r_reg.ctrl[k];
				md  = r_reg.mode[k][tmcs_pkg::MODE_LSB +: 4];
				src = src_pick(k, cr[tmcs_pkg::CS_LSB +: 3],
					tick.pre_rise, tick.pre_fall,
					tick.pin_rise, tick.pin_fall,
					ch2_overflow_i | ch2_underflow_i);
				// phase counting takes the counter away from the prescaler
				r_next.tick[k] = edge_sel(cr[tmcs_pkg::EDGE_LSB +: 2], src) &&
					!in_phase(k, md);
				r_next.c_ev[k] = cmp_c_event_i[k] &
					!r_reg.mode[k][tmcs_pkg::BUF_A];
				r_next.d_ev[k] = cmp_d_event_i[k] &
					!r_reg.mode[k][tmcs_pkg::BUF_B];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			r_reg       <= '0;
			r_reg.ctrl  <= {tmcs_pkg::NCH{tmcs_pkg::CTRL_RST}};
			r_reg.mode  <= {tmcs_pkg::NCH{tmcs_pkg::MODE_RST}};
			r_reg.sync  <= tmcs_pkg::SYNC_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs: data from flops, mode decodes straight off the mode flops
	assign rdata_o       = r_reg.rdata;
	assign count_tick_o  = r_reg.tick;
	assign c_event_o     = r_reg.c_ev;
	assign d_event_o     = r_reg.d_ev;
	assign sync_member_o = r_reg.sync;

	for (genvar g = 0; g < tmcs_pkg::NCH; g++) begin : g_dec
		assign buffer_pair_a_o[g] = r_reg.mode[g][tmcs_pkg::BUF_A];
		assign buffer_pair_b_o[g] = r_reg.mode[g][tmcs_pkg::BUF_B];
		assign phase_mode_o[g]    = in_phase(g, r_reg.mode[g][3:0]);
		assign mode_error_o[g]    = mode_bad(g, r_reg.mode[g][3:0]);
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	chk_rsv_read_ones: assert property (
		ce_i && rd_i && (addr_i < tmcs_pkg::ADDR_SYNC) && addr_i[0]
		|=> rdata_o[7:6] == 2'h3)
		else $error("reserved mode bits did not read as one");

	chk_narrow_buf_zero: assert property (
		ce_i && wr_i && ((addr_i == 4'h3) || (addr_i == 4'h5))
		|=> ##1 (buffer_pair_a_o[2:1] == 2'h0) &&
		(buffer_pair_b_o[2:1] == 2'h0))
		else $error("buffer bits became set on channel 1 or 2");

	chk_narrow_clr_top: assert property (
		ce_i && wr_i && (addr_i == 4'h2) ##2 ce_i && rd_i &&
		(addr_i == 4'h2) |=> rdata_o[7] == 1'b0)
		else $error("channel 1 top clear bit read back as one");

	chk_phase_no_tick: assert property (
		ce_i && phase_mode_o[1] |=> !count_tick_o[1])
		else $error("channel 1 counted from its clock select in phase mode");

	chk_phase_no_tick2: assert property (
		ce_i && phase_mode_o[2] |=> !count_tick_o[2])
		else $error("channel 2 counted from its clock select in phase mode");

	chk_buf_d_mute: assert property (
		ce_i && buffer_pair_b_o[0] && cmp_d_event_i[0] |=> !d_event_o[0])
		else $error("register D event passed while it buffers B");

	chk_buf_c_pass: assert property (
		ce_i && !buffer_pair_a_o[3] && cmp_c_event_i[3] |=> c_event_o[3])
		else $error("register C event lost while not buffering");

	// the undivided tap needs one cycle after reset before it pulses
	chk_ch0_div1_tick: assert property (
		ce_i && $past(nrst_i) && (r_reg.ctrl[0][4:0] == 5'h00)
		|=> count_tick_o[0])
		else $error("channel 0 on undivided clock missed a count");

	chk_ch1_cascade: assert property (
		ce_i && (r_reg.ctrl[1][2:0] == 3'h7) && !phase_mode_o[1] &&
		ch2_overflow_i |=> count_tick_o[1])
		else $error("channel 1 missed a channel 2 overflow");

	chk_ch3_div4_tick: assert property (
		ce_i && (r_reg.ctrl[3][4:0] == 5'h01) && tick.pre_rise[1]
		|=> count_tick_o[3])
		else $error("channel 3 missed a divide by four edge");

	chk_sync_write: assert property (
		ce_i && wr_i && (addr_i == tmcs_pkg::ADDR_SYNC)
		|=> sync_member_o == $past(wdata_i[4:0]))
		else $error("sync membership did not follow the write");

	chk_mode_field: assert property (
		ce_i && wr_i && (addr_i == 4'h3) && (wdata_i[3:2] == 2'h1)
		|=> phase_mode_o[1])
		else $error("mode field write did not select phase counting");

	chk_mode_illegal: assert property (
		ce_i && wr_i && (addr_i == 4'h1) && (wdata_i[3:0] == 4'h1)
		|=> mode_error_o[0])
		else $error("prohibited mode code not flagged");

	chk_mode_readback: assert property (
		ce_i && wr_i && (addr_i == 4'h7) ##2 ce_i && rd_i && (addr_i == 4'h7)
		|=> rdata_o[5:0] == $past(wdata_i[5:0], 3))
		else $error("channel 3 mode register did not read back");

	chk_both_edges: assert property (
		ce_i && (r_reg.ctrl[0][4:0] == 5'h14) && tick.pin_fall[0]
		|=> count_tick_o[0])
		else $error("both-edge setting missed a falling pin edge");

	cov_cascade: cover property (ce_i && count_tick_o[1] &&
		(r_reg.ctrl[1][2:0] == 3'h7));
	cov_phase: cover property (phase_mode_o[2]);
	cov_buffer: cover property (buffer_pair_a_o[0] && buffer_pair_b_o[4]);
	cov_pin_tick: cover property (ce_i && count_tick_o[3] &&
		(r_reg.ctrl[3][2:0] == 3'h6));
endmodule : tmcs_timer_cfg
`default_nettype wire

/* testbench/tmcs_pin_model.sv */
// partner: external clock sources wired to the four timer pins
`timescale 1ns/1ps
`default_nettype none
module tmcs_pin_model (
	input  wire logic       sys_clk_i,
	output var  logic [3:0] pins_o
);
	// pins idle low between bursts
	initial pins_o = 4'h0;
	// each level is held four clocks so a three-flop sync never drops one
	task automatic burst(input int p, input int n);
		repeat (n) begin
			repeat (4) @(posedge sys_clk_i);
			pins_o[p] <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
			pins_o[p] <= 1'b0;
		end
	endtask : burst
endmodule : tmcs_pin_model
`default_nettype wire

/* testbench/timer_clock_select_and_mode_tb_top.sv */
// testbench: register map, clock selection, pairing and pin counting
`timescale 1ns/1ps
`default_nettype none
module timer_clock_select_and_mode_tb_top;
	typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] r; int n;}
		tmcs_row_s;
	logic       sys_clk_i, nrst_i, ce_i, wr_i, rd_i, ov_i, un_i;
	logic [3:0] addr_i, pins;
	logic [7:0] wdata_i, rdata_o, rv;
	logic [4:0] cc_i, cd_i, tick, bpa, bpb, c_o, d_o, sync, ph, merr;
	int         fails = 0, checks_done = 0, k, t0, channel_counter[5] = '{default:0};
	// n is the tick count over 1024 cycles, -1 for no count check
	tmcs_row_s  rows[] = '{
		'{4'h1,8'hF0,8'hF0,-1}, '{4'h3,8'hFF,8'hCF,-1},
		'{4'h5,8'hF0,8'hC0,-1}, '{4'h7,8'hC2,8'hC2,-1},
		'{4'h0,8'h00,8'h00,1024}, '{4'h0,8'h01,8'h01,256},
		'{4'h2,8'hFF,8'h7F,0}, '{4'h4,8'h80,8'h00,1024},
		'{4'h2,8'h02,8'h02,64}, '{4'h2,8'h03,8'h03,16},
		'{4'h2,8'h06,8'h06,4}, '{4'h4,8'h01,8'h01,256},
		'{4'h6,8'h01,8'h01,256}, '{4'h6,8'h02,8'h02,64},
		'{4'h6,8'h04,8'h04,4}, '{4'h8,8'h05,8'h05,1},
		'{4'h6,8'h11,8'h11,512}, '{4'h8,8'h0A,8'h0A,64},
		'{4'hA,8'hFF,8'h1F,-1}, '{4'hC,8'hFF,8'h00,-1},
		'{4'h3,8'hF4,8'hC4,-1}, '{4'h2,8'h02,8'h02,0},
		'{4'h5,8'hF7,8'hC7,-1}, '{4'h4,8'h01,8'h01,0}};
	// pin runs: address [15:12], control value [11:4], pin [3:0]
	logic [15:0] prs[] = '{16'h0040, 16'h0051, 16'h0062, 16'h0073,
		16'h2040, 16'h2051, 16'h4040, 16'h4051, 16'h4062, 16'h6060,
		16'h6071, 16'h8060, 16'h8071, 16'h0140};

	tmcs_timer_cfg uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .ext_clock_pin_a_i(pins[0]),
		.ext_clock_pin_b_i(pins[1]), .ext_clock_pin_c_i(pins[2]),
		.ext_clock_pin_d_i(pins[3]), .ch2_overflow_i(ov_i),
		.ch2_underflow_i(un_i), .cmp_c_event_i(cc_i), .cmp_d_event_i(cd_i),
		.count_tick_o(tick), .buffer_pair_a_o(bpa), .buffer_pair_b_o(bpb),
		.c_event_o(c_o), .d_event_o(d_o), .sync_member_o(sync),
		.phase_mode_o(ph), .mode_error_o(merr));
	tmcs_pin_model pm (.sys_clk_i(sys_clk_i), .pins_o(pins));

	////////////////////////////////////////////////////////////////////////
	// clock and per-channel tick tally
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		for (int j = 0; j < 5; j++) if (tick[j] === 1'b1) channel_counter[j] <= channel_counter[j] + 1;
	end

	////////////////////////////////////////////////////////////////////////
	// bus tasks: strobes last one cycle, read data sampled the cycle after
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(negedge sys_clk_i);
		d = rdata_o;
	endtask : rd_reg
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	// watchdog: the full run needs about 17400 cycles, so twice that plus
	initial begin
		repeat (40000) @(posedge sys_clk_i);
		fails++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{nrst_i, wr_i, rd_i, ov_i, un_i, addr_i, wdata_i, cc_i, cd_i} = '0;
		ce_i = 1'b1;
		repeat (12) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		for (int a = 0; a < 11; a++) begin
			rd_reg(4'(a), rv);
			chk("reset value", (a % 2 && a < 10) ? 8'hC0 : 8'h00, rv);
		end
		$display("test reset values done");
		// mode writes keep ones in the reserved bits; pins and wrap inputs are idle
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].w);
			rd_reg(rows[i].a, rv);
			chk("readback", rows[i].r, rv);
			if (rows[i].n >= 0) begin
				repeat (4) @(posedge sys_clk_i);
				k = rows[i].a >> 1;
				t0 = channel_counter[k];
				repeat (1024) @(posedge sys_clk_i);
				chk("ticks", 16'(rows[i].n), 16'(channel_counter[k] - t0));
			end
		end
		chk("buffer a", 5'h01, bpa);
		chk("buffer b", 5'h01, bpb);
		chk("sync members", 5'h1F, sync);
		chk("phase modes", 5'h06, ph);
		$display("test register table done");
		// buffered channel 0 drops its c and d events, channel 3 passes them
		@(posedge sys_clk_i);
		cc_i <= 5'h09;
		cd_i <= 5'h09;
		@(posedge sys_clk_i);
		cc_i <= 5'h00;
		cd_i <= 5'h00;
		@(negedge sys_clk_i);
		chk("c events", 5'h08, c_o);
		chk("d events", 5'h08, d_o);
		// a prohibited mode code is flagged on its channel only
		chk("mode error", 5'h00, merr);
		wr_reg(4'h1, 8'hF1);
		repeat (2) @(posedge sys_clk_i);
		chk("mode error", 5'h01, merr);
		$display("test events and modes done");
		// leave phase counting so the pins reach channels 1 and 2
		wr_reg(4'h3, 8'hC0);
		wr_reg(4'h5, 8'hC0);
		foreach (prs[i]) begin
			wr_reg(prs[i][15:12], prs[i][11:4]);
			repeat (6) @(posedge sys_clk_i);
			k = prs[i][15:13];
			t0 = channel_counter[k];
			pm.burst(prs[i][3:0], 5);
			repeat (8) @(posedge sys_clk_i);
			// five pulses: five rising edges, or ten with both edges
			t0 = channel_counter[k] - t0;
			rv = prs[i][8] ? 8'h0A : 8'h05;
			chk("pin ticks", rv, 16'(t0));
		end
		$display("test pin clocks done");
		// channel 1 counts channel 2 wraps in either direction
		wr_reg(4'h2, 8'h07);
		repeat (3) @(posedge sys_clk_i);
		t0 = channel_counter[1];
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk_i);
			if (i < 3) ov_i <= 1'b1;
			else un_i <= 1'b1;
			@(posedge sys_clk_i);
			ov_i <= 1'b0;
			un_i <= 1'b0;
		end
		repeat (3) @(posedge sys_clk_i);
		chk("wrap ticks", 16'h0005, 16'(channel_counter[1] - t0));
		// a write with the clock enable low is lost
		@(posedge sys_clk_i);
		ce_i <= 1'b0;
		wr_reg(4'h9, 8'hFF);
		ce_i <= 1'b1;
		rd_reg(4'h9, rv);
		chk("disabled write", 8'hC0, rv);
		// second reset in mid-run restores the initial values
		@(posedge sys_clk_i);
		nrst_i <= 1'b0;
		repeat (12) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		rd_reg(4'h1, rv);
		chk("mode after reset", 8'hC0, rv);
		chk("buffer after reset", 5'h00, bpa | bpb);
		$display("test wraps and reset done");
		conclude();
	end
endmodule : timer_clock_select_and_mode_tb_top
`default_nettype wire
